// ---- hw/srb_writer.sv ----
`timescale 1ns/1ns
// Summary of operation
// - Each channel owns its own circular buffer
// - Buffer length 64 to 1024 entries selectable
// - One length shared by a VC's buffers
// - Maximum lead caps write ahead of read
// - Lead violation reports slip, data overwritten
// - Base is prefix over 12-bit channel base
// - 64 entries use both prefix bits in address, 128 only the low one
// - Larger buffers drop prefix; 512/1024 also drop high base bits
// - Entry: flag, reserved, turn, nibble, byte
// - CAS VC flags multiframe start in entries
// - Non-CAS VC writes flag zero
// - Reserved bit always written zero
// - Turn bits are top pointer bits
// - Nibble is the channel's programmed value from config memory
// - Byte is payload or dummy fill
// - Shared pointer advances after all channels
module srb_writer
    import srb_pkg::*;
#(
    parameter int CHANNELS = 4,
    parameter int MEM_DEPTH = 128
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Byte stream from the reassembler
    input wire srb_pkg::srb_byte_in_t byte_in,
    // Write port toward external buffer memory
    output srb_pkg::srb_mem_wr_t mem_wr,
    output logic mem_wr_valid,
    // Slip report
    output logic slip_pulse
);
    import srb_pkg::*;

    localparam int CW = $clog2(CHANNELS);
    localparam int MW = $clog2(MEM_DEPTH);

    // Refuse sizes the channel index and config memory cannot serve
    if (CHANNELS < 2 || CHANNELS > 128) begin : g_bad_channels
        $error("CHANNELS out of range");
    end
    if (MEM_DEPTH < CHANNELS) begin : g_bad_depth
        $error("MEM_DEPTH too small");
    end

    function automatic logic [10:0] entries_of(input srb_len_sel_t sel);
        case (sel)
            SRB_LEN_64: entries_of = 11'h040;
            SRB_LEN_128: entries_of = 11'h080;
            SRB_LEN_256: entries_of = 11'h100;
            SRB_LEN_512: entries_of = 11'h200;
            default: entries_of = 11'h400;
        endcase
    endfunction

    // Register state
    logic [15:0] ctrl_q, ctrl_d;
    logic [15:0] vc_q, vc_d;
    logic [CW-1:0] sel_q, sel_d;
    logic [9:0] rdptr_q, rdptr_d;
    logic [15:0] rdata_q, rdata_d;
    logic slip_sts_q, slip_sts_d;

    // Per-channel config memory: base and programmed nibble
    logic cfg_we;
    logic [15:0] cfg_rdata;
    logic [MW-1:0] cfg_raddr;
    logic [MW-1:0] cfg_waddr;

    srb_chan_mem #(
        .DEPTH(MEM_DEPTH),
        .WIDTH(16)
    ) u_cfg (
        .clk_sys(clk_sys),
        .we(cfg_we),
        .waddr(cfg_waddr),
        .wdata(reg_wdata),
        .raddr(cfg_raddr),
        .rdata(cfg_rdata)
    );

    srb_len_sel_t len_sel;
    logic [1:0] prefix;
    logic cas_en;
    logic ds1;
    logic [10:0] max_lead;
    assign len_sel = srb_len_sel_t'(vc_q[SRB_VC_LEN_LSB +: 3]);
    assign prefix = ctrl_q[SRB_CTRL_PREFIX_LSB +: 2];
    assign cas_en = vc_q[SRB_VC_CAS_BIT];
    assign ds1 = vc_q[SRB_VC_DS1_BIT];
    assign max_lead = {1'b0, vc_q[SRB_VC_LEAD_LSB +: 10]};

    // Write pipeline
    typedef enum logic [1:0] {
        SRB_ST_IDLE = 2'b00,
        SRB_ST_FETCH = 2'b01,
        SRB_ST_WRITE = 2'b11
    } srb_state_t;

    srb_state_t st_q, st_d;
    logic [CW-1:0] cur_q, cur_d;
    logic [9:0] wptr_q, wptr_d;
    logic [4:0] frame_q, frame_d;
    logic mf_q, mf_d;
    logic [7:0] byte_q, byte_d;
    srb_mem_wr_t wr_q, wr_d;
    logic wv_q, wv_d;
    logic slip_q, slip_d;
    logic [19:0] addr;
    logic [10:0] lead;
    logic [10:0] len;
    logic last_ch;

    assign cfg_raddr = MW'(st_q == SRB_ST_IDLE ? sel_q : cur_q);
    assign cfg_waddr = MW'(sel_q);
    assign len = entries_of(len_sel);
    // Distance of write pointer ahead of read pointer, modulo length
    assign lead = ((11'({1'b0, wptr_q}) - 11'({1'b0, rdptr_q})) & (len - 11'h001));
    assign last_ch = cur_q == CW'(CHANNELS - 1);

    srb_addr_form u_addr (
        .prefix(prefix),
        .base(cfg_rdata[SRB_CH_BASE_LSB +: 12]),
        .len_sel(len_sel),
        .wptr(wptr_q),
        .addr(addr)
    );

    always_comb begin
        st_d = st_q;
        cur_d = cur_q;
        wptr_d = wptr_q;
        frame_d = frame_q;
        mf_d = mf_q;
        byte_d = byte_q;
        wr_d = wr_q;
        wv_d = 1'b0;
        slip_d = 1'b0;
        case (st_q)
            SRB_ST_IDLE: begin
                if (byte_in.valid) begin
                    // Dummy cells carry the programmed fill
                    byte_d = byte_in.dummy ? ctrl_q[SRB_CTRL_FILL_LSB +: 8]
                                           : byte_in.data;
                    st_d = SRB_ST_FETCH;
                end
            end
            SRB_ST_FETCH: begin
                st_d = SRB_ST_WRITE;
            end
            default: begin
                // One buffer per channel, selected by its own base
                wr_d.addr = addr;
                wr_d.entry.mf = cas_en & mf_q;
                wr_d.entry.res = 1'b0;
                // Turn is the top two bits of the index within the buffer
                case (len_sel)
                    SRB_LEN_64: wr_d.entry.turn = wptr_q[5:4];
                    SRB_LEN_128: wr_d.entry.turn = wptr_q[6:5];
                    SRB_LEN_256: wr_d.entry.turn = wptr_q[7:6];
                    SRB_LEN_512: wr_d.entry.turn = wptr_q[8:7];
                    default: wr_d.entry.turn = wptr_q[9:8];
                endcase
                // Nibble is the channel's programmed value, read each entry
                wr_d.entry.cas = cfg_rdata[SRB_CH_CAS_LSB +: 4];
                wr_d.entry.data = byte_q;
                wv_d = 1'b1;
                st_d = SRB_ST_IDLE;
                if (last_ch) begin
                    cur_d = '0;
                    mf_d = 1'b0;
                    // At the lead limit: slip, restart one entry past the read pointer
                    if (lead >= max_lead) begin
                        slip_d = 1'b1;
                        wptr_d = 10'(rdptr_q + 10'h001);
                    end else begin
                        wptr_d = 10'(wptr_q + 10'h001);
                    end
                    if (cas_en) begin
                        if (frame_q == (ds1 ? SRB_MF_DS1 : SRB_MF_E1) - 5'h01) begin
                            frame_d = '0;
                            mf_d = 1'b1;
                        end else begin
                            frame_d = 5'(frame_q + 5'h01);
                        end
                    end
                end else begin
                    cur_d = CW'(cur_q + 1'b1);
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_q <= SRB_ST_IDLE;
            cur_q <= '0;
            wptr_q <= '0;
            frame_q <= '0;
            mf_q <= 1'b0;
            byte_q <= '0;
            wr_q <= '0;
            wv_q <= 1'b0;
            slip_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cur_q <= cur_d;
            wptr_q <= wptr_d;
            frame_q <= frame_d;
            mf_q <= mf_d;
            byte_q <= byte_d;
            wr_q <= wr_d;
            wv_q <= wv_d;
            slip_q <= slip_d;
        end
    end

    assign mem_wr = wr_q;
    assign mem_wr_valid = wv_q;
    assign slip_pulse = slip_q;

    // Register access
    assign cfg_we = reg_wr && reg_addr == SRB_REG_CHAN_CFG;

    always_comb begin
        ctrl_d = ctrl_q;
        vc_d = vc_q;
        sel_d = sel_q;
        rdptr_d = rdptr_q;
        rdata_d = '0;
        // Slip event wins over a clear in the same cycle
        slip_sts_d = slip_sts_q;
        if (reg_wr && reg_addr == SRB_REG_STATUS && reg_wdata[0]) begin
            slip_sts_d = 1'b0;
        end
        if (slip_q) begin
            slip_sts_d = 1'b1;
        end
        if (reg_wr) begin
            if (reg_addr == SRB_REG_CTRL) begin
                ctrl_d = reg_wdata;
            end else if (reg_addr == SRB_REG_VC_CFG) begin
                vc_d = reg_wdata;
            end else if (reg_addr == SRB_REG_RDPTR) begin
                rdptr_d = reg_wdata[9:0];
            end
        end
        if (reg_rd) begin
            if (reg_addr == SRB_REG_CTRL) begin
                rdata_d = ctrl_q;
            end else if (reg_addr == SRB_REG_VC_CFG) begin
                rdata_d = vc_q;
            end else if (reg_addr == SRB_REG_STATUS) begin
                rdata_d = {5'h00, wptr_q, slip_sts_q};
            end else if (reg_addr == SRB_REG_RDPTR) begin
                rdata_d = {6'h00, rdptr_q};
            end
        end
        if (reg_wr && reg_addr == SRB_REG_CTRL) begin
            sel_d = sel_q;
        end
        if (reg_wr && reg_addr == SRB_REG_CHAN_CFG) begin
            sel_d = CW'(sel_q + 1'b1);
        end
        if (reg_wr && reg_addr == SRB_REG_VC_CFG) begin
            sel_d = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_q <= SRB_CTRL_RESET;
            vc_q <= SRB_VC_RESET;
            sel_q <= '0;
            rdptr_q <= '0;
            rdata_q <= '0;
            slip_sts_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            vc_q <= vc_d;
            sel_q <= sel_d;
            rdptr_q <= rdptr_d;
            rdata_q <= rdata_d;
            slip_sts_q <= slip_sts_d;
        end
    end

    assign reg_rdata = rdata_q;

    // Checks
    a_res_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mem_wr_valid |-> !mem_wr.entry.res) else $error("reserved bit set");
    a_mf_noncas: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mem_wr_valid && !cas_en) |-> !mem_wr.entry.mf) else $error("flag in non-CAS VC");
    a_wptr_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st_q == SRB_ST_WRITE && !last_ch) |=> wptr_q == $past(wptr_q))
        else $error("pointer moved mid-frame");
    a_slip_lead: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st_q == SRB_ST_WRITE && last_ch && lead >= max_lead) |=> slip_pulse)
        else $error("slip missed");
    a_write_lat: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st_q == SRB_ST_IDLE && byte_in.valid) |-> ##3 mem_wr_valid)
        else $error("write late");
    a_addr_64: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mem_wr_valid && len_sel == SRB_LEN_64 && $stable(vc_q))
        |-> mem_wr.addr[19:18] == prefix) else $error("prefix missing");
    a_turn_bits: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st_q == SRB_ST_WRITE && len_sel == SRB_LEN_1024)
        |=> mem_wr.entry.turn == $past(wptr_q[9:8]))
        else $error("turn bits wrong");
    a_dummy_fill: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st_q == SRB_ST_IDLE && byte_in.valid && byte_in.dummy && $stable(ctrl_q))
        |=> byte_q == ctrl_q[SRB_CTRL_FILL_LSB +: 8]) else $error("fill wrong");
endmodule // srb_writer

// ---- hw/srb_pkg.sv ----
package srb_pkg;

    // Register map
    localparam logic [15:0] SRB_REG_CTRL = 16'h2040;
    localparam logic [15:0] SRB_REG_VC_CFG = 16'h2042;
    localparam logic [15:0] SRB_REG_CHAN_CFG = 16'h2044;
    localparam logic [15:0] SRB_REG_STATUS = 16'h2046;
    localparam logic [15:0] SRB_REG_RDPTR = 16'h2048;

    // Control register fields
    localparam int SRB_CTRL_PREFIX_LSB = 0;
    localparam int SRB_CTRL_FILL_LSB = 8;
    localparam logic [15:0] SRB_CTRL_RESET = 16'h0000;

    // Per-VC configuration fields
    localparam int SRB_VC_LEN_LSB = 0;
    localparam int SRB_VC_CAS_BIT = 3;
    localparam int SRB_VC_DS1_BIT = 4;
    localparam int SRB_VC_LEAD_LSB = 5;
    localparam logic [15:0] SRB_VC_RESET = 16'h0000;

    // Per-channel configuration fields
    localparam int SRB_CH_BASE_LSB = 0;
    localparam int SRB_CH_CAS_LSB = 12;

    // Multiframe lengths in frames
    localparam logic [4:0] SRB_MF_DS1 = 5'h18;
    localparam logic [4:0] SRB_MF_E1 = 5'h10;

    typedef enum logic [2:0] {
        SRB_LEN_64 = 3'h0,
        SRB_LEN_128 = 3'h1,
        SRB_LEN_256 = 3'h2,
        SRB_LEN_512 = 3'h3,
        SRB_LEN_1024 = 3'h4
    } srb_len_sel_t;

    typedef struct packed {
        logic mf;
        logic res;
        logic [1:0] turn;
        logic [3:0] cas;
        logic [7:0] data;
    } srb_entry_t;

    typedef struct packed {
        logic [19:0] addr;
        srb_entry_t entry;
    } srb_mem_wr_t;

    typedef struct packed {
        logic valid;
        logic dummy;
        logic [7:0] data;
    } srb_byte_in_t;

endpackage

// ---- hw/srb_chan_mem.sv ----
`timescale 1ns/1ns
module srb_chan_mem #(
    parameter int DEPTH = 128,
    parameter int WIDTH = 16
) (
    // Clock
    input wire logic clk_sys,
    // Write port
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // Read port
    input wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // srb_chan_mem

// ---- hw/srb_addr_form.sv ----
`timescale 1ns/1ns
module srb_addr_form
    import srb_pkg::*;
(
    // Inputs
    input wire logic [1:0] prefix,
    input wire logic [11:0] base,
    input wire srb_pkg::srb_len_sel_t len_sel,
    input wire logic [9:0] wptr,
    // Entry address
    output logic [19:0] addr
);
    import srb_pkg::*;

    always_comb begin
        // Prefix over base over wrapped pointer, cut to the low 20 bits
        case (len_sel)
            SRB_LEN_64: addr = {prefix, base, wptr[5:0]};
            SRB_LEN_128: addr = {prefix[0], base, wptr[6:0]};
            SRB_LEN_256: addr = {base, wptr[7:0]};
            SRB_LEN_512: addr = {base[10:0], wptr[8:0]};
            default: addr = {base[9:0], wptr[9:0]};
        endcase
    end
endmodule // srb_addr_form

// ---- tb/srb_mem_model.sv ----
`timescale 1ns/1ns
module srb_mem_model
    import srb_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Write port from the writer
    input wire srb_mem_wr_t mem_wr,
    input wire logic mem_wr_valid
);
    import srb_pkg::*;
    srb_entry_t store [logic [19:0]];
    int writes = 0;

    // External memory takes every entry that the writer offers
    always @(posedge clk_sys) begin
        if (mem_wr_valid === 1'b1) begin
            store[mem_wr.addr] = mem_wr.entry;
            writes++;
        end
    end
endmodule // srb_mem_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    import srb_pkg::*;
    localparam int CH = 4;
    localparam logic [1:0] PFX = 2'h2;
    localparam logic [11:0] BASE = 12'hA50;
    localparam logic [7:0] FILL = 8'hC3;
    localparam logic [9:0] RDP = 10'h005;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    srb_byte_in_t byte_in = '0;
    srb_mem_wr_t mem_wr;
    logic mem_wr_valid;
    logic slip_pulse;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    int sent = 0;
    logic [9:0] wptr = '0;

    always #5 clk_sys = ~clk_sys;

    srb_writer #(.CHANNELS(CH)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .byte_in(byte_in), .mem_wr(mem_wr), .mem_wr_valid(mem_wr_valid), .slip_pulse(slip_pulse));
    srb_mem_model mem (.clk_sys(clk_sys), .mem_wr(mem_wr), .mem_wr_valid(mem_wr_valid));

    task automatic end_of_test();
        $display("mismatches %0d checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Ceiling well above the roughly 5500 cycles the sequence needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic check(input logic [19:0] seen, input logic [19:0] want);
        checks_done++;
        if (seen !== want) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic do_reset();
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (20) @(posedge clk_sys);
        #1 check(20'({mem_wr_valid, slip_pulse, reg_rdata}), 20'h0);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        wptr = '0;
    endtask

    task automatic setup(input srb_len_sel_t ls, input logic cas_on, input logic ds1,
                         input logic [9:0] lead);
        do_reset();
        reg_write(SRB_REG_CTRL, {FILL, 6'h00, PFX});
        reg_write(SRB_REG_VC_CFG, {1'b0, lead, ds1, cas_on, ls});
        for (int c = 0; c < CH; c++) begin
            reg_write(SRB_REG_CHAN_CFG, {4'(9 - c), BASE + 12'(c)});
        end
    endtask

    function automatic logic [19:0] exp_addr(srb_len_sel_t ls, logic [11:0] b, logic [9:0] w);
        case (ls)
            SRB_LEN_64: return {PFX, b, w[5:0]};
            SRB_LEN_128: return {PFX[0], b, w[6:0]};
            SRB_LEN_256: return {b, w[7:0]};
            SRB_LEN_512: return {b[10:0], w[8:0]};
            default: return {b[9:0], w};
        endcase
    endfunction

    // Turn shows which quarter of the buffer the pointer is in
    function automatic logic [1:0] exp_turn(srb_len_sel_t ls, logic [9:0] w);
        case (ls)
            SRB_LEN_64: return w[5:4];
            SRB_LEN_128: return w[6:5];
            SRB_LEN_256: return w[7:6];
            SRB_LEN_512: return w[8:7];
            default: return w[9:8];
        endcase
    endfunction

    // One byte per channel, then the shared pointer moves on
    task automatic frame(input srb_len_sel_t ls, input logic cas_on, input logic mf,
                         input logic dmy, input logic slip);
        logic [7:0] d;
        logic dy;
        srb_entry_t e;
        for (int c = 0; c < CH; c++) begin
            d = wptr[7:0] ^ 8'(c * 17);
            dy = dmy && (c % 2 == 1);
            @(posedge clk_sys);
            byte_in <= '{1'b1, dy, d};
            @(posedge clk_sys);
            byte_in.valid <= 1'b0;
            sent++;
            repeat (2) @(posedge clk_sys);
            #1 check(20'(mem_wr_valid), 20'h1);
            e = '{mf, 1'b0, exp_turn(ls, wptr), 4'(9 - c), dy ? FILL : d};
            check(mem_wr.addr, exp_addr(ls, BASE + 12'(c), wptr));
            check(20'(slip_pulse), 20'(slip && c == CH - 1));
            check(20'(mem_wr.entry), 20'(e));
            if (cas_on) begin
                check(20'({mem_wr.entry.mf, mem_wr.entry.res}), 20'({mf, 1'b0}));
            end
        end
        wptr = slip ? RDP + 10'h001 : wptr + 10'h001;
    endtask

    initial begin
        logic [15:0] r;
        int fl;
        do_reset();
        reg_read(SRB_REG_CTRL, r);
        check(20'(r), 20'(SRB_CTRL_RESET));
        reg_read(SRB_REG_VC_CFG, r);
        check(20'(r), 20'(SRB_VC_RESET));
        reg_read(16'h2050, r);
        check(20'(r), 20'h0);
        setup(SRB_LEN_64, 1'b0, 1'b0, 10'h3FF);
        reg_read(SRB_REG_CTRL, r);
        check(20'(r), 20'({FILL, 6'h00, PFX}));
        // Long run wraps the 64-entry buffer through every turn value
        repeat (260) frame(SRB_LEN_64, 1'b0, 1'b0, 1'b0, 1'b0);
        for (int b = 0; b < 5; b++) begin
            setup(srb_len_sel_t'(b), 1'b0, 1'b0, 10'h3FF);
            repeat (3) frame(srb_len_sel_t'(b), 1'b0, 1'b0, 1'b1, 1'b0);
        end
        for (int m = 0; m < 2; m++) begin
            fl = int'(m == 1 ? SRB_MF_DS1 : SRB_MF_E1);
            setup(SRB_LEN_256, 1'b1, m == 1, 10'h3FF);
            for (int f = 0; f <= fl; f++) begin
                frame(SRB_LEN_256, 1'b1, f == fl, 1'b0, 1'b0);
            end
        end
        // Read pointer ahead of writer with lead limit 3 forces a slip on the first frame
        setup(SRB_LEN_64, 1'b0, 1'b0, 10'h003);
        reg_write(SRB_REG_RDPTR, 16'(RDP));
        frame(SRB_LEN_64, 1'b0, 1'b0, 1'b0, 1'b1);
        reg_read(SRB_REG_STATUS, r);
        check(20'(r[10:0]), 20'({RDP + 10'h001, 1'b1}));
        reg_write(SRB_REG_STATUS, 16'h0001);
        reg_read(SRB_REG_STATUS, r);
        check(20'(r[0]), 20'h0);
        frame(SRB_LEN_64, 1'b0, 1'b0, 1'b0, 1'b0);
        @(posedge clk_sys);
        #1 check(20'(mem.writes), 20'(sent));
        // Last entry of channel 3 at pointer 6: turn 0, nibble 6, byte 06h xor 33h
        r = mem.store[exp_addr(SRB_LEN_64, BASE + 12'h003, 10'h006)];
        check(20'(r), 20'h00635);
        end_of_test();
    end
endmodule // testbench
